// *** hw/lds_status.v ***
// Diagnostic status words, fault reactions and output gating
`include "lds_consts.vh"

// Channel order of every vector: bridge vectors run from output one
// high side in the top bit down to output six low side in bit zero;
// high-side vectors run from output seven in the top bit down to the
// electrochromic output in bit zero. Comparator inputs are asynchronous
// levels; commands and configuration words come from logic on this clock.
// Outputs are all registered so the pins never see decode glitches.

module lds_status #(
	parameter OL_CYCLES = `LDS_OL_FILT_CYC,
	parameter EC_CYCLES = `LDS_EC_FILT_CYC,
	parameter RETRY_CYCLES = `LDS_OC_RETRY_CYC,
	parameter NBR = 12,
	parameter NHS = 6
) (
	input wire clk,
	input wire sys_rst,
	input wire [NBR-1:0] br_on,
	input wire [NHS-1:0] hs_on,
	input wire [NBR-1:0] br_below,
	input wire [NHS-1:0] hs_below,
	input wire [NHS-1:0] hs_oc,
	input wire vs_under,
	input wire vs_over,
	input wire ec_mode,
	input wire ec_below_target,
	input wire ec_above_target,
	input wire oc_recovery_en,
	input wire [15:0] cfg_word,
	input wire [15:0] ctrl3_word,
	input wire rd_en,
	input wire rd_sel,
	output reg [15:0] rd_data,
	output reg rd_valid,
	input wire clr_en,
	input wire clr_sel,
	input wire [15:0] clr_bits,
	output reg [NBR-1:0] br_drive,
	output reg [NHS-1:0] hs_drive,
	output reg open_load_summary,
	output reg global_error
);

	localparam NS = NBR + 2 * NHS + 4;
	localparam RW = $clog2(RETRY_CYCLES) + 1;
	localparam integer RETRY_LAST_I = RETRY_CYCLES - 1;
	localparam [RW-1:0] RETRY_LAST = RETRY_LAST_I[RW-1:0];

	// Synchronised analog comparator levels
	wire [NS-1:0] pins_raw;
	wire [NS-1:0] pins_s;
	wire [NBR-1:0] br_below_s;
	wire [NHS-1:0] hs_below_s;
	wire [NHS-1:0] hs_oc_s;
	wire vs_under_s;
	wire vs_over_s;
	wire ec_below_s;
	wire ec_above_s;

	// Filtered conditions
	wire [NBR-1:0] br_low_cond;
	wire [NHS-1:0] hs_low_cond;
	wire [NBR-1:0] br_low_long;
	wire [NHS-1:0] hs_low_long;
	wire [1:0] ec_cond;
	wire [1:0] ec_held;

	// Latched flags and driver state
	reg [NBR-1:0] br_uc_reg;
	reg [NBR-1:0] br_uc_next;
	reg [NHS-1:0] high_side_undercurrent_flag_reg;
	reg [NHS-1:0] high_side_undercurrent_flag_next;
	reg [NHS-1:0] hs_ocf_reg;
	reg [NHS-1:0] hs_ocf_next;
	reg [NHS-1:0] oc_off_reg;
	reg [NHS-1:0] oc_off_next;
	reg vs_uv_reg;
	reg vs_uv_next;
	reg vs_ov_reg;
	reg vs_ov_next;
	reg sup_off_reg;
	reg sup_off_next;

	// Clear decode and helper terms
	wire clr_uc_word;
	wire clr_fault_word;
	wire [NBR-1:0] br_clr;
	wire [NHS-1:0] hs_oc_clr;
	wire [NHS-1:0] high_side_undercurrent_flag_clr;
	wire [NHS-1:0] retry_done;
	wire supply_bad;
	wire [15:0] uc_word;
	wire [15:0] fault_word;
	wire [NBR-1:0] br_ol_masked;
	wire [1:0] ec_flags;
	// Supply clear terms and first-output mask
	wire vs_uv_clr;
	wire vs_ov_clr;
	wire [NBR-1:0] ol_mask;

	// All analog levels share one synchroniser bank
	assign pins_raw = {br_below, hs_below, hs_oc, vs_under, vs_over,
		ec_below_target, ec_above_target};

	lds_sync #(
		.WIDTH(NS)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.din(pins_raw),
		.dout(pins_s)
	);

	// Unpack in the packing order
	assign br_below_s = pins_s[NS-1 -: NBR];
	assign hs_below_s = pins_s[2*NHS+3 -: NHS];
	assign hs_oc_s = pins_s[NHS+3 -: NHS];
	assign vs_under_s = pins_s[3];
	assign vs_over_s = pins_s[2];
	assign ec_below_s = pins_s[1];
	assign ec_above_s = pins_s[0];

	assign br_low_cond = br_drive & br_below_s;
	assign hs_low_cond = hs_drive & hs_below_s;

	// The filter delays the fall too, so a clear within one filter time
	// of recovery is refused: the lagging output sets the flag again
	// 1 ms persistence
	lds_follow #(
		.WIDTH(NBR + NHS),
		.N(OL_CYCLES)
	) u_ol_filt (
		.clk(clk),
		.sys_rst(sys_rst),
		.din({br_low_cond, hs_low_cond}),
		.dout({br_low_long, hs_low_long})
	);

	assign ec_cond = {ec_mode & ec_below_s, ec_mode & ec_above_s};

	lds_follow #(
		.WIDTH(2),
		.N(EC_CYCLES)
	) u_ec_filt (
		.clk(clk),
		.sys_rst(sys_rst),
		.din(ec_cond),
		.dout(ec_held)
	);

	// Leaving the mode zeroes both flags at once, not after the filter
	// live, unlatched flags
	assign ec_flags = ec_held & {2{ec_mode}};

	// Controller clears apply to the selected word only
	assign clr_uc_word = clr_en & (clr_sel == `LDS_SEL_UC_WORD);
	assign clr_fault_word = clr_en & (clr_sel == `LDS_SEL_FAULT_WORD);
	assign br_clr = {NBR{clr_uc_word}} & clr_bits[15 -: NBR];
	// Supply flag clears, word two only
	assign vs_uv_clr = clr_fault_word & clr_bits[`LDS_POS_VS_UNDER];
	assign vs_ov_clr = clr_fault_word & clr_bits[`LDS_POS_VS_OVER];

	// Pair bits of the fault word, top channel first
	// Channel k sits at pair OCP, its under-current flag just below
	genvar k;
	generate
		for (k = 0; k < NHS; k = k + 1) begin : g_pair
			localparam OCP = `LDS_POS_PAIR_TOP - 2 * (NHS - 1 - k);
			assign hs_oc_clr[k] = clr_fault_word & clr_bits[OCP];
			assign high_side_undercurrent_flag_clr[k] = clr_fault_word & clr_bits[OCP-1];
			assign fault_word[OCP] = hs_ocf_reg[k];
			assign fault_word[OCP-1] = high_side_undercurrent_flag_reg[k];
		end
	endgenerate

	assign uc_word = {br_uc_reg, 4'h0};
	assign fault_word[`LDS_POS_VS_UNDER] = vs_uv_reg;
	assign fault_word[`LDS_POS_VS_OVER] = vs_ov_reg;
	assign fault_word[`LDS_POS_EC_LOW] = ec_flags[1];
	assign fault_word[`LDS_POS_EC_HIGH] = ec_flags[0];

	// Per-channel retry timers after an over-current trip
	// One fixed wait for all channels; the duty cycle follows the fault length
	generate
		for (k = 0; k < NHS; k = k + 1) begin : g_retry
			reg [RW-1:0] cnt_reg;
			assign retry_done[k] = oc_off_reg[k] & oc_recovery_en & ~hs_oc_s[k] &
				(cnt_reg == RETRY_LAST);
			// Timer restarts whenever the fault is still present
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_reg <= {RW{1'b0}};
				end else if (!oc_off_reg[k] || !oc_recovery_en || hs_oc_s[k]) begin
					cnt_reg <= {RW{1'b0}};
				end else if (cnt_reg != RETRY_LAST) begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	endgenerate

	// Either supply comparator forces the shutdown
	assign supply_bad = vs_under_s | vs_over_s;

	// Next values of flags and off states; sets beat clears
	always @* begin
		br_uc_next = (br_uc_reg & ~br_clr) | br_low_long;
		high_side_undercurrent_flag_next = (high_side_undercurrent_flag_reg & ~high_side_undercurrent_flag_clr) | hs_low_long;
		hs_ocf_next = (hs_ocf_reg & ~hs_oc_clr) | hs_oc_s;
		oc_off_next = oc_off_reg | hs_oc_s;
		if (oc_recovery_en) begin
			oc_off_next = (oc_off_reg & ~retry_done) | hs_oc_s;
		end else begin
			oc_off_next = (oc_off_reg & hs_ocf_next) | hs_oc_s;
		end
		vs_uv_next = (vs_uv_reg & ~vs_uv_clr) | vs_under_s;
		vs_ov_next = (vs_ov_reg & ~vs_ov_clr) | vs_over_s;
		// With the hold bit set, only clearing both flags ends the off state
		// restart unless inhibited
		if (supply_bad) begin
			sup_off_next = 1'b1;
		end else if (!ctrl3_word[`LDS_CTRL3_NO_RESTART]) begin
			sup_off_next = 1'b0;
		end else begin
			sup_off_next = sup_off_reg & (vs_uv_next | vs_ov_next);
		end
	end

	// Flag and state registers
	// The over-current flag stays set after a timed retry so it can be read
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			br_uc_reg <= {NBR{1'b0}};
			high_side_undercurrent_flag_reg <= {NHS{1'b0}};
			hs_ocf_reg <= {NHS{1'b0}};
			oc_off_reg <= {NHS{1'b0}};
			vs_uv_reg <= 1'b0;
			vs_ov_reg <= 1'b0;
			sup_off_reg <= 1'b0;
		end else begin
			br_uc_reg <= br_uc_next;
			high_side_undercurrent_flag_reg <= high_side_undercurrent_flag_next;
			hs_ocf_reg <= hs_ocf_next;
			oc_off_reg <= oc_off_next;
			vs_uv_reg <= vs_uv_next;
			vs_ov_reg <= vs_ov_next;
			sup_off_reg <= sup_off_next;
		end
	end

	// Driver gating uses next states so a trip removes drive at the same edge that latches the off state
	// Bridge over-current is handled elsewhere, so bridges see supply gating only
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			br_drive <= {NBR{1'b0}};
			hs_drive <= {NHS{1'b0}};
		end else begin
			br_drive <= br_on & {NBR{~sup_off_next}};
			hs_drive <= hs_on & ~oc_off_next & {NHS{~sup_off_next}};
		end
	end

	assign ol_mask = {cfg_word[`LDS_CFG_MASK_HS1], cfg_word[`LDS_CFG_MASK_LS1],
		{(NBR-2){1'b0}}};
	assign br_ol_masked = br_uc_reg & ~ol_mask;

	// Summary outputs; temperature lies outside this block
	// Under-current flags feed the global flag unless config bit 1 masks them
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			open_load_summary <= 1'b0;
			global_error <= 1'b0;
		end else begin
			open_load_summary <= (|br_ol_masked) | (|high_side_undercurrent_flag_reg);
			global_error <= (|hs_ocf_reg) | vs_uv_reg | vs_ov_reg |
				(~cfg_word[`LDS_CFG_MASK_OL_GLOBAL] & ((|br_uc_reg) | (|high_side_undercurrent_flag_reg)));
		end
	end

	// Reads have no side effect; clearing is an explicit request
	// rd_valid pulses for one cycle per accepted read
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= `LDS_STATUS_RST;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= (rd_sel == `LDS_SEL_FAULT_WORD) ? fault_word : uc_word;
			end
		end
	end

endmodule

// *** hw/lds_consts.vh ***
// Constants for the load diagnostic status block
`ifndef LDS_CONSTS_VH
`define LDS_CONSTS_VH

// Clock rate and filter times
`define LDS_CLK_MHZ 250
`define LDS_OL_FILT_US 1000
`define LDS_EC_FILT_US 32
`define LDS_OC_RETRY_US 100
`define LDS_OL_FILT_CYC (`LDS_OL_FILT_US * `LDS_CLK_MHZ)
`define LDS_EC_FILT_CYC (`LDS_EC_FILT_US * `LDS_CLK_MHZ)
`define LDS_OC_RETRY_CYC (`LDS_OC_RETRY_US * `LDS_CLK_MHZ)

// Word select codes for read and clear
`define LDS_SEL_UC_WORD 1'b0
`define LDS_SEL_FAULT_WORD 1'b1

// Status word reset value
`define LDS_STATUS_RST 16'h0000

// Fault word field positions
`define LDS_POS_PAIR_TOP 15
`define LDS_POS_VS_UNDER 3
`define LDS_POS_VS_OVER 2
`define LDS_POS_EC_LOW 1
`define LDS_POS_EC_HIGH 0

// Configuration and control bit positions
`define LDS_CFG_MASK_HS1 5
`define LDS_CFG_MASK_LS1 4
`define LDS_CFG_MASK_OL_GLOBAL 1
`define LDS_CTRL3_NO_RESTART 4

`endif

// *** hw/lds_sync.v ***
// Three-stage input synchroniser with agree-based change
module lds_sync #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire sys_rst,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

	reg [WIDTH-1:0] s1_reg;
	reg [WIDTH-1:0] s2_reg;
	reg [WIDTH-1:0] s3_reg;
	wire [WIDTH-1:0] agree;

	// Only bits where stages two and three agree may move the output
	assign agree = ~(s2_reg ^ s3_reg);

	// First stage is read by the second alone
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= {WIDTH{1'b0}};
			s2_reg <= {WIDTH{1'b0}};
			s3_reg <= {WIDTH{1'b0}};
			dout <= {WIDTH{1'b0}};
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			dout <= (agree & s2_reg) | (~agree & dout);
		end
	end

endmodule

// *** hw/lds_follow.v ***
// Per-bit persistence filter: output takes input after N steady cycles
module lds_follow #(
	parameter WIDTH = 1,
	parameter N = 8000
) (
	input wire clk,
	input wire sys_rst,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);

	localparam CW = $clog2(N) + 1;
	localparam integer LAST_I = N - 1;
	localparam [CW-1:0] LAST = LAST_I[CW-1:0];

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg [CW-1:0] cnt_reg;
			// Any return to the old level restarts the count
			always @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					cnt_reg <= {CW{1'b0}};
					dout[i] <= 1'b0;
				end else if (din[i] == dout[i]) begin
					cnt_reg <= {CW{1'b0}};
				end else if (cnt_reg == LAST) begin
					cnt_reg <= {CW{1'b0}};
					dout[i] <= din[i];
				end else begin
					cnt_reg <= cnt_reg + 1'b1;
				end
			end
		end
	endgenerate

endmodule

// *** hw/dummy_never.v ***
// Spare file that holds no logic

// *** verif/lds_status_checker.sv ***
// Port checker for the load diagnostic status block
module lds_status_checker (
	input wire clk,
	input wire sys_rst,
	input wire [11:0] br_on,
	input wire [11:0] br_drive,
	input wire [5:0] hs_oc,
	input wire [5:0] hs_drive,
	input wire vs_under,
	input wire vs_over,
	input wire ec_mode,
	input wire [15:0] ctrl3_word,
	input wire rd_en,
	input wire rd_sel,
	input wire [15:0] rd_data,
	input wire rd_valid,
	input wire clr_en
);
	timeunit 1ns;
	timeprecision 1ps;
	// Supply fault and hold-off bit
	wire vs_bad = vs_under | vs_over;
	wire hold3 = ctrl3_word[4];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Read port answers once and data holds between reads
	AST_RD_VALID: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	AST_RD_HOLD: assert property (!$past(rd_en) |-> $stable(rd_data))
		else $error("read data moved");
	AST_WORD1_LOW: assert property (rd_valid && !$past(rd_sel)
		|-> rd_data[3:0] == 4'h0) else $error("word one low bits set");
	// Drives only where commanded; long faults force them off
	AST_DRIVE_ON: assert property ((br_drive & ~$past(br_on)) == 12'h000)
		else $error("bridge driven unasked");
	AST_OC_OFF: assert property (hs_oc[5] [*8] |-> !hs_drive[5])
		else $error("overcurrent output on");
	AST_VS_OFF: assert property (vs_bad [*8]
		|-> br_drive == 12'h000 && hs_drive == 6'h00) else $error("supply fault outputs on");
	AST_NO_RESTART: assert property ((hold3 && vs_bad) [*8]
		##1 (hold3 && !clr_en) [*8] |-> hs_drive == 6'h00) else $error("restart despite hold");
	// Comparator bits read zero outside the mode
	AST_EC_MODE: assert property (rd_valid && $past(rd_sel) && !$past(ec_mode)
		|-> rd_data[1:0] == 2'b00) else $error("ec bits outside mode");
	cover property (rd_valid && rd_data != 16'h0000);
	cover property ($fell(hs_drive[5]));
	cover property ($rose(br_drive[11]));
endmodule

bind lds_status lds_status_checker lds_status_checker_i (.clk, .sys_rst, .br_on, .br_drive,
	.hs_oc, .hs_drive, .vs_under, .vs_over, .ec_mode, .ctrl3_word, .rd_en, .rd_sel, .rd_data,
	.rd_valid, .clr_en);

// *** verif/lds_mcu.sv ***
// Controller model that reads and clears the status words
module lds_mcu (
	input wire clk,
	input wire [15:0] rd_data,
	input wire rd_valid,
	output logic rd_en,
	output logic rd_sel,
	output logic clr_en,
	output logic clr_sel,
	output logic [15:0] clr_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle request lines at time zero
	initial begin
		rd_en = 1'b0;
		rd_sel = 1'b0;
		clr_en = 1'b0;
		clr_sel = 1'b0;
		clr_bits = 16'h0000;
	end
	// Answer sampled before the design drops it at the third edge
	task automatic read_word(input logic sel, output logic [15:0] data, output logic ok);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_sel <= sel;
		@(posedge clk);
		rd_en <= 1'b0;
		rd_sel <= ~sel;
		@(posedge clk);
		ok = rd_valid;
		data = rd_data;
	endtask
	task automatic clear_word(input logic sel, input logic [15:0] bits);
		@(posedge clk);
		clr_en <= 1'b1;
		clr_sel <= sel;
		clr_bits <= bits;
		@(posedge clk);
		clr_en <= 1'b0;
		clr_bits <= ~bits;
	endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the load diagnostic status block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] br_on = 12'h000;
	logic [11:0] br_below = 12'h000;
	logic [5:0] hs_on = 6'h00;
	logic [5:0] hs_below = 6'h00;
	logic [5:0] hs_oc = 6'h00;
	logic vs_under = 1'b0;
	logic vs_over = 1'b0;
	logic ec_mode = 1'b0;
	logic ec_below_target = 1'b0;
	logic ec_above_target = 1'b0;
	logic oc_recovery_en = 1'b0;
	logic [15:0] cfg_word = 16'h0000;
	logic [15:0] ctrl3_word = 16'h0000;
	logic rd_en, rd_sel, rd_valid, clr_en, clr_sel, open_load_summary, global_error, ok;
	logic [15:0] rd_data, clr_bits, w;
	logic [11:0] br_drive;
	logic [5:0] hs_drive;
	int miscompares = 0;
	int n_compared = 0;
	// Short filters keep the run brief
	lds_status #(.OL_CYCLES(20), .EC_CYCLES(8), .RETRY_CYCLES(10)) lds_status_i (.clk, .sys_rst,
		.br_on, .hs_on, .br_below, .hs_below, .hs_oc, .vs_under, .vs_over, .ec_mode,
		.ec_below_target, .ec_above_target, .oc_recovery_en, .cfg_word, .ctrl3_word, .rd_en,
		.rd_sel, .rd_data, .rd_valid, .clr_en, .clr_sel, .clr_bits, .br_drive, .hs_drive,
		.open_load_summary, .global_error);
	lds_mcu lds_mcu_i (.clk, .rd_data, .rd_valid, .rd_en, .rd_sel, .clr_en, .clr_sel, .clr_bits);
	initial forever #2 clk = ~clk;
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rd(input logic sel, input logic [15:0] exp, input string name);
		lds_mcu_i.read_word(sel, w, ok);
		chk("rd_valid", 16'(ok), 16'h0001);
		chk(name, w, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic stop_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Short dip ignored, long low latches, masking of output one
	task automatic t_uc;
		br_on <= 12'hfff;
		hs_below <= 6'h3f;
		br_below <= 12'h002;
		tick(10);
		br_below <= 12'h000;
		tick(5);
		br_below <= 12'hc01;
		tick(40);
		rd(1'b0, 16'hc010, "uc word");
		rd(1'b1, 16'h0000, "off stages");
		br_below <= 12'h000;
		hs_below <= 6'h00;
		// The filter also delays the fall, so wait it out before clearing
		tick(30);
		lds_mcu_i.clear_word(1'b0, 16'h0010);
		cfg_word <= 16'h0032;
		tick(4);
		chk("ol masked", 16'(open_load_summary), 16'h0000);
		chk("ge masked", 16'(global_error), 16'h0000);
		cfg_word <= 16'h0000;
		tick(4);
		chk("ol summary", 16'(open_load_summary), 16'h0001);
		chk("ge summary", 16'(global_error), 16'h0001);
		lds_mcu_i.clear_word(1'b0, 16'hffff);
		rd(1'b0, 16'h0000, "uc cleared");
	endtask
	// Latched trip, manual then automatic restart
	task automatic t_oc;
		hs_on <= 6'h3f;
		hs_oc <= 6'h20;
		tick(10);
		hs_oc <= 6'h00;
		tick(20);
		chk("hs_drive", 16'(hs_drive), 16'h001f);
		chk("global_error", 16'(global_error), 16'h0001);
		rd(1'b1, 16'h8000, "oc flag");
		lds_mcu_i.clear_word(1'b1, 16'h8000);
		tick(2);
		chk("hs_drive", 16'(hs_drive), 16'h003f);
		oc_recovery_en <= 1'b1;
		hs_oc <= 6'h10;
		tick(10);
		hs_oc <= 6'h00;
		tick(30);
		chk("hs_drive", 16'(hs_drive), 16'h003f);
		rd(1'b1, 16'h2000, "oc kept");
		lds_mcu_i.clear_word(1'b1, 16'hffff);
	endtask
	// Supply faults with and without restart hold
	task automatic t_vs;
		vs_under <= 1'b1;
		tick(10);
		chk("br_drive", 16'(br_drive), 16'h0000);
		vs_under <= 1'b0;
		tick(10);
		chk("br_drive", 16'(br_drive), 16'h0fff);
		rd(1'b1, 16'h0008, "vs flag");
		ctrl3_word <= 16'h0010;
		vs_over <= 1'b1;
		tick(10);
		vs_over <= 1'b0;
		tick(10);
		chk("hs held", 16'(hs_drive), 16'h0000);
		lds_mcu_i.clear_word(1'b1, 16'h000c);
		tick(2);
		chk("hs back", 16'(hs_drive), 16'h003f);
		ctrl3_word <= 16'h0000;
	endtask
	// Comparator filter, live following, no error summary
	task automatic t_ec;
		ec_mode <= 1'b1;
		ec_below_target <= 1'b1;
		tick(6);
		ec_below_target <= 1'b0;
		tick(10);
		rd(1'b1, 16'h0000, "ec short");
		ec_above_target <= 1'b1;
		tick(20);
		rd(1'b1, 16'h0001, "ec high");
		chk("global_error", 16'(global_error), 16'h0000);
		lds_mcu_i.clear_word(1'b1, 16'h0003);
		ec_above_target <= 1'b0;
		ec_below_target <= 1'b1;
		tick(20);
		rd(1'b1, 16'h0002, "ec low");
		ec_mode <= 1'b0;
		tick(2);
		rd(1'b1, 16'h0000, "ec off");
	endtask
	// Hang guard
	initial begin
		tick(20000);
		miscompares++;
		stop_test;
	end
	initial begin
		tick(5);
		sys_rst <= 1'b0;
		tick(2);
		t_uc;
		t_oc;
		t_vs;
		t_ec;
		stop_test;
	end
endmodule
